//--- ssc_pkg.sv
// Purpose: Shared constants and types for the flag-semaphore port controller
// Assumes: 125 MHz core_clk; one port of the dual-port part is driven
// Notes: Flag access time is an assumed default; raise T_ACC_NS for a slower part
package ssc_pkg;
    localparam int CLK_PS = 8000;
    localparam int T_WP_NS = 15;
    localparam int T_SWR_NS = 10;
    localparam int T_ACC_NS = 70;
    // Pin to usable filtered value: three stages plus the filter register
    localparam int SYNC_LAT = 4;
    localparam int NUM_FLAGS = 8;
    localparam int IDX_W = 3;
    localparam int DATA_W = 8;
    localparam int CNT_W = 4;

    // Least time rounded up to whole cycles, never below one
    function automatic int ns2cyc(input int ns);
        int c;
        c = (ns * 1000 + CLK_PS - 1) / CLK_PS;
        return (c < 1) ? 1 : c;
    endfunction : ns2cyc

    localparam logic [CNT_W-1:0] WP_LAST = CNT_W'(ns2cyc(T_WP_NS) - 1);
    localparam logic [CNT_W-1:0] SWR_LAST = CNT_W'(ns2cyc(T_SWR_NS) - 1);
    localparam logic [CNT_W-1:0] ACC_LAST = CNT_W'(ns2cyc(T_ACC_NS) + SYNC_LAT - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
    localparam logic [IDX_W-1:0] IDX_FIRST = 3'h0;
    localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(NUM_FLAGS - 1);
    localparam logic [IDX_W-1:0] IDX_ONE = 3'h1;
    localparam logic WBIT_REQ = 1'b0;
    localparam logic WBIT_REL = 1'b1;
    localparam logic [DATA_W-2:0] DATA_HI_ZERO = 7'h00;
    localparam logic [DATA_W-1:0] DATA_ALL_ZERO = 8'h00;

    typedef enum logic [2:0] {
        OP_REQ = 3'h0,
        OP_REL = 3'h1,
        OP_READ = 3'h2,
        OP_ACQ = 3'h3,
        OP_INIT = 3'h4
    } ssc_op_t;

    typedef struct packed {
        ssc_op_t op;
        logic [IDX_W-1:0] index;
    } ssc_cmd_t;

    typedef struct packed {
        logic mem_select_n;
        logic flag_select_n;
        logic write_n;
        logic oe_n;
        logic [IDX_W-1:0] flag_index;
        logic [DATA_W-1:0] data_out;
        logic data_oe;
    } ssc_pins_t;

    localparam ssc_pins_t PINS_IDLE = '{mem_select_n: 1'b1, flag_select_n: 1'b1, write_n: 1'b1,
        oe_n: 1'b1, flag_index: 3'h0, data_out: 8'h00, data_oe: 1'b0};

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_SETUP = 6'h02,
        ST_WRITE = 6'h04,
        ST_RECOV = 6'h08,
        ST_READ = 6'h10,
        ST_DONE = 6'h20
    } ssc_state_t;
endpackage : ssc_pkg

//--- ssc_ctrl.sv
// Purpose: Host controller driving one port's flag-semaphore pins
// Assumes: Flag data pins arrive asynchronously and are filtered here
// Notes: Memory array is never accessed; memory select is held high
`timescale 1ns/1ps
module ssc_ctrl (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // User command port
    input wire logic cmd_valid,
    input wire ssc_pkg::ssc_cmd_t cmd,
    output logic cmd_ready,
    // User response
    output logic resp_valid,
    output logic resp_owned,
    // Device port pins
    output ssc_pkg::ssc_pins_t pins,
    input wire logic [ssc_pkg::DATA_W-1:0] data_in
);
    ssc_pkg::ssc_state_t state_q, state_d;
    logic [ssc_pkg::CNT_W-1:0] cnt_q, cnt_d;
    ssc_pkg::ssc_cmd_t cmd_q, cmd_d;
    ssc_pkg::ssc_pins_t pins_q, pins_d;
    logic wbit_q, wbit_d;
    logic fail_q, fail_d;
    logic owned_q, owned_d;
    logic ready_q, ready_d;
    logic rv_q, rv_d;
    logic ro_q, ro_d;
    logic [ssc_pkg::DATA_W-1:0] s1_q, s2_q, s3_q, filt_q, filt_d;

    // A bit moves only when the second and third stages agree
    always_comb begin
        filt_d = (s2_q & s3_q) | (filt_q & (s2_q ^ s3_q));
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s1_q <= ssc_pkg::DATA_ALL_ZERO;
            s2_q <= ssc_pkg::DATA_ALL_ZERO;
            s3_q <= ssc_pkg::DATA_ALL_ZERO;
            filt_q <= ssc_pkg::DATA_ALL_ZERO;
        end else begin
            s1_q <= data_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            filt_q <= filt_d;
        end
    end

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        cmd_d = cmd_q;
        pins_d = pins_q;
        wbit_d = wbit_q;
        fail_d = fail_q;
        owned_d = owned_q;
        ready_d = ready_q;
        rv_d = 1'b0;
        ro_d = ro_q;
        pins_d.mem_select_n = 1'b1;
        case (state_q)
            ssc_pkg::ST_IDLE: begin
                if (cmd_valid && ready_q) begin
                    cmd_d = cmd;
                    ready_d = 1'b0;
                    fail_d = 1'b0;
                    owned_d = 1'b0;
                    cnt_d = ssc_pkg::CNT_ZERO;
                    pins_d.flag_index = (cmd.op == ssc_pkg::OP_INIT) ? ssc_pkg::IDX_FIRST : cmd.index;
                    pins_d.flag_select_n = 1'b0;
                    if (cmd.op == ssc_pkg::OP_READ) begin
                        pins_d.oe_n = 1'b0;
                        state_d = ssc_pkg::ST_READ;
                    end else begin
                        // Request on REQ and ACQ, release otherwise
                        wbit_d = (cmd.op == ssc_pkg::OP_REQ || cmd.op == ssc_pkg::OP_ACQ) ?
                            ssc_pkg::WBIT_REQ : ssc_pkg::WBIT_REL;
                        state_d = ssc_pkg::ST_SETUP;
                    end
                end
            end
            ssc_pkg::ST_SETUP: begin
                // Strobe falls a cycle after select so the address has settled
                pins_d.write_n = 1'b0;
                pins_d.data_out = {ssc_pkg::DATA_HI_ZERO, wbit_q};
                pins_d.data_oe = 1'b1;
                cnt_d = ssc_pkg::CNT_ZERO;
                state_d = ssc_pkg::ST_WRITE;
            end
            ssc_pkg::ST_WRITE: begin
                cnt_d = cnt_q + ssc_pkg::CNT_ONE;
                if (cnt_q == ssc_pkg::WP_LAST) begin
                    pins_d.write_n = 1'b1;
                    pins_d.data_oe = 1'b0;
                    cnt_d = ssc_pkg::CNT_ZERO;
                    state_d = ssc_pkg::ST_RECOV;
                end
            end
            ssc_pkg::ST_RECOV: begin
                cnt_d = cnt_q + ssc_pkg::CNT_ONE;
                if (cnt_q == ssc_pkg::SWR_LAST) begin
                    cnt_d = ssc_pkg::CNT_ZERO;
                    if (cmd_q.op == ssc_pkg::OP_ACQ && !fail_q) begin
                        pins_d.oe_n = 1'b0;
                        state_d = ssc_pkg::ST_READ;
                    end else begin
                        state_d = ssc_pkg::ST_DONE;
                    end
                end
            end
            ssc_pkg::ST_READ: begin
                cnt_d = cnt_q + ssc_pkg::CNT_ONE;
                if (cnt_q == ssc_pkg::ACC_LAST) begin
                    owned_d = (filt_q == ssc_pkg::DATA_ALL_ZERO);
                    pins_d.oe_n = 1'b1;
                    cnt_d = ssc_pkg::CNT_ZERO;
                    state_d = ssc_pkg::ST_DONE;
                end
            end
            ssc_pkg::ST_DONE: begin
                if (cmd_q.op == ssc_pkg::OP_INIT && pins_q.flag_index != ssc_pkg::IDX_LAST) begin
                    pins_d.flag_index = pins_q.flag_index + ssc_pkg::IDX_ONE;
                    state_d = ssc_pkg::ST_SETUP;
                end else if (cmd_q.op == ssc_pkg::OP_ACQ && !owned_q && !fail_q) begin
                    // A lost request is withdrawn so a stale latch cannot hang the peer
                    fail_d = 1'b1;
                    wbit_d = ssc_pkg::WBIT_REL;
                    state_d = ssc_pkg::ST_SETUP;
                end else begin
                    pins_d.flag_select_n = 1'b1;
                    rv_d = 1'b1;
                    ro_d = owned_q;
                    ready_d = 1'b1;
                    state_d = ssc_pkg::ST_IDLE;
                end
            end
            default: begin
                pins_d = ssc_pkg::PINS_IDLE;
                ready_d = 1'b1;
                state_d = ssc_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= ssc_pkg::ST_IDLE;
            cnt_q <= ssc_pkg::CNT_ZERO;
            cmd_q <= '{op: ssc_pkg::OP_REQ, index: 3'h0};
            pins_q <= ssc_pkg::PINS_IDLE;
            wbit_q <= ssc_pkg::WBIT_REL;
            fail_q <= 1'b0;
            owned_q <= 1'b0;
            ready_q <= 1'b1;
            rv_q <= 1'b0;
            ro_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            cmd_q <= cmd_d;
            pins_q <= pins_d;
            wbit_q <= wbit_d;
            fail_q <= fail_d;
            owned_q <= owned_d;
            ready_q <= ready_d;
            rv_q <= rv_d;
            ro_q <= ro_d;
        end
    end

    assign cmd_ready = ready_q;
    assign resp_valid = rv_q;
    assign resp_owned = ro_q;
    assign pins = pins_q;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    sequence s_acq_write;
        $rose(pins_q.write_n) && cmd_q.op == ssc_pkg::OP_ACQ && !fail_q;
    endsequence
    sequence s_hold_then_read;
        (!pins_q.flag_select_n && pins_q.oe_n) [*2] ##1 (!pins_q.flag_select_n && !pins_q.oe_n);
    endsequence

    a_write_qual: assert property (!pins_q.write_n |-> !pins_q.flag_select_n)
        else $error("strobe low without flag select");
    a_wr_width: assert property ($fell(pins_q.write_n) |-> !pins_q.write_n [*2])
        else $error("write pulse shorter than two cycles");
    a_addr_hold: assert property ($changed(pins_q.flag_index) |-> pins_q.write_n && $past(pins_q.write_n))
        else $error("flag index moved during write");
    a_mem_sel_off: assert property (pins_q.mem_select_n)
        else $error("memory select driven low");
    a_data_lsb: assert property (pins_q.data_oe |-> !pins_q.write_n && pins_q.data_out[7:1] == 7'h00)
        else $error("data driven outside write or upper bits set");
    a_acq_readback: assert property (s_acq_write |-> s_hold_then_read)
        else $error("acquire readback not under held flag select");
    a_read_gap: assert property (rv_q |-> pins_q.oe_n && pins_q.flag_select_n)
        else $error("read enables not dropped at response");
    a_fail_release: assert property (state_q == ssc_pkg::ST_DONE && cmd_q.op == ssc_pkg::OP_ACQ && !owned_q
        && !fail_q |-> ##2 (!pins_q.write_n && pins_q.data_out[0]))
        else $error("lost request not withdrawn");
endmodule : ssc_ctrl

//--- ssc_flag_dev.sv
// Purpose: Behavioural model of the two-port semaphore flag logic
// Assumes: Port A pins come from the controller; the bench plays port B
// Notes: Flags start in a stale state on purpose, as after power-up
`timescale 1ns/1ps
module ssc_flag_dev #(
    parameter int ACC_NS = 60
) (
    // Port A
    input wire ssc_pkg::ssc_pins_t pins,
    output logic [ssc_pkg::DATA_W-1:0] data_in,
    // Port B
    input wire logic b_write_n,
    input wire logic [ssc_pkg::IDX_W-1:0] b_index,
    input wire logic b_bit,
    output logic b_flag
);
    // Request latches (1 = zero request held) and owner 0 free, 1 A, 2 B
    logic [7:0] req_a;
    logic [7:0] req_b;
    logic [1:0] owner [8];
    logic [7:0] cap_v;
    logic rd_n;
    // Each write acts atomically, so a near tie still lands on one side
    task automatic put(input logic [1:0] p, input logic [2:0] i, input logic d);
        if (p == 2'h1) req_a[i] = ~d;
        else req_b[i] = ~d;
        if (!d && owner[i] == 2'h0) owner[i] = p;
        else if (d && owner[i] == p) owner[i] = ((p == 2'h1) ? req_b[i] : req_a[i]) ? 2'h3 - p : 2'h0;
    endtask : put
    initial begin
        req_a = 8'hff;
        req_b = 8'h0f;
        for (int i = 0; i < 8; i++) owner[i] = i[0] ? 2'h1 : 2'h2;
        cap_v = 8'h5a;
    end
    assign rd_n = pins.flag_select_n | pins.oe_n;
    always @(posedge pins.write_n) begin
        if (pins.flag_select_n === 1'b0 && pins.mem_select_n === 1'b1) put(2'h1, pins.flag_index, pins.data_out[0]);
    end
    always @(posedge b_write_n) put(2'h2, b_index, b_bit);
    always @(negedge rd_n) cap_v = {8{owner[pins.flag_index] != 2'h1}};
    // Released lines show the inverse, never a stale copy
    assign #(ACC_NS) data_in = rd_n ? ~cap_v : cap_v;
    assign b_flag = owner[b_index] != 2'h2;
endmodule : ssc_flag_dev

//--- tb_ssc_ctrl.sv
// Purpose: Self-checking bench for the flag-semaphore port controller
// Assumes: One device model; the bench plays the far port
// Notes: Expected values follow the token-passing rules
`timescale 1ns/1ps
module tb_ssc_ctrl;
    logic core_clk, sys_rst, cmd_valid, b_write_n, b_bit, b_flag;
    logic cmd_ready, resp_valid, resp_owned;
    logic [2:0] b_index, widx;
    logic [7:0] data_in;
    ssc_pkg::ssc_cmd_t cmd;
    ssc_pkg::ssc_pins_t pins;
    int error_cnt, cmp_count, cyc, wlen;
    ssc_ctrl DUT (.core_clk(core_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd(cmd),
        .cmd_ready(cmd_ready), .resp_valid(resp_valid), .resp_owned(resp_owned), .pins(pins), .data_in(data_in));
    ssc_flag_dev #(.ACC_NS(60)) dev (.pins(pins), .data_in(data_in), .b_write_n(b_write_n),
        .b_index(b_index), .b_bit(b_bit), .b_flag(b_flag));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic summarize();
        $display("errors=%0d compares=%0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize
    task automatic run(input ssc_pkg::ssc_op_t op, input logic [2:0] idx);
        int n;
        n = 0;
        chk(8'(cmd_ready), 8'h01);
        cmd = '{op: op, index: idx};
        cmd_valid = 1'b1;
        @(posedge core_clk);
        #1;
        cmd_valid = 1'b0;
        while (resp_valid !== 1'b1 && n < 100) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        chk(8'(resp_valid), 8'h01);
        @(posedge core_clk);
        #1;
    endtask : run
    task automatic b_wr(input logic [2:0] idx, input logic d);
        b_index = idx;
        b_bit = d;
        #2 b_write_n = 1'b0;
        #20 b_write_n = 1'b1;
        #2;
    endtask : b_wr
    task automatic t_init();
        run(ssc_pkg::OP_INIT, 3'h0);
        chk(8'(resp_owned), 8'h00);
        for (int i = 0; i < 8; i++) b_wr(3'(i), 1'b1);
        for (int i = 0; i < 8; i++) chk(8'(dev.owner[i]), 8'h00);
    endtask : t_init
    task automatic t_take_pass();
        run(ssc_pkg::OP_ACQ, 3'h3);
        chk(8'(resp_owned), 8'h01);
        b_wr(3'h3, 1'b0);
        chk(8'(b_flag), 8'h01);
        run(ssc_pkg::OP_REL, 3'h3);
        chk(8'(b_flag), 8'h00);
        run(ssc_pkg::OP_READ, 3'h3);
        chk(8'(resp_owned), 8'h00);
        b_wr(3'h3, 1'b1);
    endtask : t_take_pass
    task automatic t_lost();
        b_wr(3'h5, 1'b0);
        run(ssc_pkg::OP_ACQ, 3'h5);
        chk(8'(resp_owned), 8'h00);
        chk(8'(dev.req_a[5]), 8'h00);
        b_wr(3'h5, 1'b1);
        chk(8'(dev.owner[5]), 8'h00);
    endtask : t_lost
    task automatic t_last_flag();
        run(ssc_pkg::OP_REQ, 3'h7);
        run(ssc_pkg::OP_READ, 3'h7);
        chk(8'(resp_owned), 8'h01);
        run(ssc_pkg::OP_REL, 3'h7);
        run(ssc_pkg::OP_READ, 3'h7);
        chk(8'(resp_owned), 8'h00);
    endtask : t_last_flag
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    // Hang guard; a full run needs well under 1000 cycles
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 4000) begin
            error_cnt++;
            summarize();
        end
    end
    // Pin watch: index steady and pulse width fixed during each write
    always @(posedge core_clk) begin
        if (!sys_rst && pins.write_n === 1'b0) begin
            if (wlen == 0) widx = pins.flag_index;
            else chk(8'(pins.flag_index), 8'(widx));
            chk(8'(pins.flag_select_n), 8'h00);
            chk(8'(pins.mem_select_n), 8'h01);
            wlen++;
        end else if (wlen != 0) begin
            chk(8'(wlen), 8'(ssc_pkg::WP_LAST) + 8'h01);
            wlen = 0;
        end
    end
    initial begin
        sys_rst = 1'b1;
        cmd_valid = 1'b0;
        cmd = '0;
        b_write_n = 1'b1;
        b_bit = 1'b1;
        b_index = 3'h0;
        repeat (16) @(posedge core_clk);
        #1;
        sys_rst = 1'b0;
        @(posedge core_clk);
        #1;
        chk(8'(pins.flag_select_n), 8'h01);
        t_init();
        t_take_pass();
        t_lost();
        t_last_flag();
        summarize();
    end
endmodule : tb_ssc_ctrl
